// >>> pciu_pkg.sv
// constants, codes and states shared by the io/clock instruction unit
// assumes a 20 MHz system clock and a scan-paced user program
// Summary of operation
// - pot index 0..255, else operand error
// - pot reading 0..255 stored to destination
// - continuous variant: filter 0..64 ms, clamp
// - stepped variant: 0/8/16/32/64, round down
// - filter on points 0..15, not high-speed
// - io refresh at scan end, or instantly when first and count are multiples of 8
// - each save lengthens scan 2..5 ms
// - save only on enable rising edge
// - print low bytes of words, strobe point
// - busy flag held during print
// - 8 bytes, or 1..16 ending before zero
// - enable invalid clears busy flag
// - one print per valid enable period
// - clock read copies seven fields in order
// - clock read fails on clock setting error
// - clock write refused unless valid date
package pciu_pkg;
  typedef enum logic [2:0] {
    OP_POT = 3'h0, OP_FILT = 3'h1, OP_REF_IN = 3'h2, OP_REF_OUT = 3'h3,
    OP_NV = 3'h4, OP_PRINT = 3'h5, OP_CLK_RD = 3'h6, OP_CLK_WR = 3'h7
  } pciu_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_POT = 3'h1, ST_RD = 3'h2, ST_RWAIT = 3'h3,
    ST_RDATA = 3'h4, ST_NVH = 3'h5, ST_CLKRD = 3'h6, ST_CLKCHK = 3'h7
  } pciu_state_t;
  localparam logic [15:0] POT_MAX = 16'h00FF;
  localparam logic [6:0] FILT_MAX = 7'h40;
  localparam logic [6:0] FILT_S1 = 7'h08;
  localparam logic [6:0] FILT_S2 = 7'h10;
  localparam logic [6:0] FILT_S3 = 7'h20;
  localparam int FILT_POINTS = 16;
  localparam logic [15:0] IO_ALL = 16'h0100;
  localparam logic [15:0] NV_FIRST = 16'h1770;
  localparam logic [15:0] NV_END = 16'h1B58;
  localparam logic [4:0] NV_CNT_LIM = 5'h10;
  localparam int CLK_KHZ = 20000;
  localparam int NV_MIN_MS = 2;
  localparam int NV_MAX_MS = 5;
  localparam int NV_MIN_CYC = NV_MIN_MS * CLK_KHZ;
  localparam int NV_MAX_CYC = NV_MAX_MS * CLK_KHZ;
  localparam logic [4:0] PR_SHORT = 5'h08;
  localparam logic [4:0] PR_LONG = 5'h10;
  localparam int CLK_FIELDS = 7;
  localparam int FIFO_W = 32;
  localparam int FIFO_D = 8;
  localparam logic [15:0] YEAR_MIN = 16'h07D0;
  localparam logic [15:0] YEAR_MAX = 16'h0833;
  localparam logic [15:0] MONTH_MAX = 16'h000C;
  localparam logic [15:0] HOUR_LIM = 16'h0018;
  localparam logic [15:0] MIN_LIM = 16'h003C;
  localparam logic [15:0] WEEK_LIM = 16'h0007;
  localparam logic [15:0] YEAR_RST = YEAR_MIN;
  localparam logic [15:0] ONE_RST = 16'h0001;
endpackage

// >>> pciu_fifo.sv
// first-in first-out buffer with valid/ready on both sides
// assumes one clock, synchronous active-high reset, common clock enable
`timescale 1ns/1ps
module pciu_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rp_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> pciu_unit.sv
// io and real-time clock instruction executor, one command per handshake
// assumes a word memory with one-cycle read latency and a scan-end pulse
`timescale 1ns/1ps
module pciu_unit import pciu_pkg::*; #(
  parameter int NV_MIN = NV_MIN_CYC,
  parameter int NV_MAX = NV_MAX_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic scan_end_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire pciu_op_t cmd_op_i,
  input wire logic cmd_power_i,
  input wire logic [15:0] cmd_a_i,
  input wire logic [15:0] cmd_b_i,
  output logic done_o,
  output logic err_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  output logic [7:0] pot_index_o,
  input wire logic [7:0] pot_value_i,
  input wire logic variant_stepped_i,
  input wire logic [15:0] high_speed_i,
  output logic [6:0] filter_time_o,
  output logic [15:0] filtered_input_points_o,
  output logic io_refresh_o,
  output logic [1:0] io_dir_o,
  output logic [15:0] io_first_o,
  output logic [15:0] io_count_o,
  output logic nv_valid_o,
  input wire logic nv_ready_i,
  output logic [15:0] nv_addr_o,
  output logic [15:0] nv_data_o,
  input wire logic print_length_flag_i,
  output logic print_busy_flag_o,
  output logic print_strobe_point_o,
  output logic [7:0] print_data_o,
  input wire logic rtc_fault_i,
  input wire logic [2:0] clock_sel_i,
  output logic [15:0] clock_data_o
);
  pciu_state_t state_reg;
  pciu_op_t op_reg;
  logic [15:0] base_reg;
  logic [4:0] idx_reg;
  logic [4:0] cnt_reg;
  logic [16:0] nv_tmr_reg;
  logic nv_prev_reg;
  logic pr_prev_reg;
  logic [7:0] pbuf_reg [16];
  logic [15:0] stage_reg [CLK_FIELDS];
  logic [15:0] rtc_reg [CLK_FIELDS];
  logic pr_loaded_reg;
  logic pr_phase_reg;
  logic pr_len_reg;
  logic busy_reg;
  logic [4:0] pr_pos_reg;
  logic [6:0] filt_reg;
  logic take;
  logic fifo_in_ready;
  logic fifo_empty_n;
  logic [31:0] fifo_out;
  logic pr_begin;
  logic pr_cancel;
  logic pr_go;
  logic [4:0] pr_lim;
  logic date_ok;

  assign cmd_ready_o = (state_reg == ST_IDLE) && !scan_end_i;
  assign take = cmd_valid_i && cmd_ready_o && ce_i;
  assign pr_begin = take && cmd_op_i == OP_PRINT && cmd_power_i && !pr_prev_reg;
  assign pr_cancel = take && cmd_op_i == OP_PRINT && !cmd_power_i;
  assign pr_go = state_reg == ST_RDATA && op_reg == OP_PRINT && idx_reg + 5'h01 == cnt_reg;
  assign pr_lim = pr_len_reg ? PR_LONG : PR_SHORT;
  assign filter_time_o = filt_reg;
  assign print_busy_flag_o = busy_reg;
  assign nv_addr_o = fifo_out[31:16];
  assign nv_data_o = fifo_out[15:0];
  assign nv_valid_o = fifo_empty_n;

  function automatic logic [6:0] filt_q(input logic [15:0] v, input logic stepped);
    logic [6:0] r;
    r = (v > 16'(FILT_MAX)) ? FILT_MAX : v[6:0];
    if (stepped) begin
      if (r < FILT_S1) r = 7'h00;
      else if (r < FILT_S2) r = FILT_S1;
      else if (r < FILT_S3) r = FILT_S2;
      else if (r < FILT_MAX) r = FILT_S3;
      else r = FILT_MAX;
    end
    return r;
  endfunction

  // solar calendar check, leap years are multiples of four within 2000..2099
  always_comb begin
    logic [15:0] dim;
    dim = 16'h001F;
    case (stage_reg[1][3:0])
      4'h4, 4'h6, 4'h9, 4'hB: dim = 16'h001E;
      4'h2: dim = (stage_reg[0][1:0] == 2'h0) ? 16'h001D : 16'h001C;
      default: dim = 16'h001F;
    endcase
    date_ok = stage_reg[0] >= YEAR_MIN && stage_reg[0] <= YEAR_MAX
      && stage_reg[1] >= ONE_RST && stage_reg[1] <= MONTH_MAX
      && stage_reg[2] >= ONE_RST && stage_reg[2] <= dim
      && stage_reg[3] < HOUR_LIM && stage_reg[4] < MIN_LIM
      && stage_reg[5] < MIN_LIM && stage_reg[6] < WEEK_LIM;
  end

  pciu_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(state_reg == ST_RDATA && op_reg == OP_NV),
    .in_ready_o(fifo_in_ready),
    .in_data_i({base_reg + 16'(idx_reg), mem_rdata_i}),
    .out_valid_o(fifo_empty_n),
    .out_ready_i(nv_ready_i),
    .out_data_o(fifo_out)
  );

  // sequencer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_POT;
      base_reg <= 16'h0000;
      idx_reg <= 5'h00;
      cnt_reg <= 5'h00;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 16'h0000;
      pot_index_o <= 8'h00;
      done_o <= 1'b0;
      err_o <= 1'b0;
      nv_tmr_reg <= 17'h00000;
    end else if (ce_i) begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      mem_wr_o <= 1'b0;
      // saturates so a stalled save never counts past the limit
      if (op_reg == OP_NV && state_reg != ST_IDLE && nv_tmr_reg < 17'(NV_MAX)) begin
        nv_tmr_reg <= nv_tmr_reg + 17'h00001;
      end
      case (state_reg)
        ST_IDLE: begin
          if (take && cmd_power_i) begin
            op_reg <= cmd_op_i;
            base_reg <= cmd_b_i;
            idx_reg <= 5'h00;
            nv_tmr_reg <= 17'h00000;
            case (cmd_op_i)
              OP_POT: begin
                if (cmd_a_i > POT_MAX) err_o <= 1'b1;
                else begin
                  pot_index_o <= cmd_a_i[7:0];
                  state_reg <= ST_POT;
                end
              end
              OP_NV: begin
                base_reg <= cmd_a_i;
                cnt_reg <= cmd_b_i[4:0];
                if (nv_prev_reg) done_o <= 1'b1;
                else if (cmd_a_i < NV_FIRST || cmd_b_i >= 16'(NV_CNT_LIM)
                    || cmd_a_i >= NV_END || cmd_a_i + cmd_b_i >= NV_END) err_o <= 1'b1;
                else state_reg <= (cmd_b_i == 16'h0000) ? ST_NVH : ST_RD;
              end
              OP_PRINT: begin
                base_reg <= cmd_a_i;
                cnt_reg <= print_length_flag_i ? PR_LONG : PR_SHORT;
                if (pr_begin) state_reg <= ST_RD;
                else done_o <= 1'b1;
              end
              OP_CLK_RD: begin
                if (rtc_fault_i) err_o <= 1'b1;
                else state_reg <= ST_CLKRD;
              end
              OP_CLK_WR: begin
                base_reg <= cmd_a_i;
                cnt_reg <= 5'(CLK_FIELDS);
                state_reg <= ST_RD;
              end
              default: begin
                done_o <= 1'b1;
              end
            endcase
          end else if (take) begin
            done_o <= 1'b1;
          end
        end
        ST_POT: begin
          mem_wr_o <= 1'b1;
          mem_addr_o <= base_reg;
          mem_wdata_o <= {8'h00, pot_value_i};
          done_o <= 1'b1;
          state_reg <= ST_IDLE;
        end
        ST_RD: begin
          if (op_reg != OP_NV || fifo_in_ready) begin
            mem_rd_o <= 1'b1;
            mem_addr_o <= base_reg + 16'(idx_reg);
            state_reg <= ST_RWAIT;
          end
        end
        ST_RWAIT: begin
          mem_rd_o <= 1'b0;
          state_reg <= ST_RDATA;
        end
        ST_RDATA: begin
          idx_reg <= idx_reg + 5'h01;
          if (idx_reg + 5'h01 != cnt_reg) state_reg <= ST_RD;
          else if (op_reg == OP_NV) state_reg <= ST_NVH;
          else if (op_reg == OP_CLK_WR) state_reg <= ST_CLKCHK;
          else begin
            done_o <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_NVH: begin
          if ((nv_tmr_reg >= 17'(NV_MIN) && !fifo_empty_n)
              || nv_tmr_reg >= 17'(NV_MAX)) begin
            done_o <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_CLKRD: begin
          mem_wr_o <= 1'b1;
          mem_addr_o <= base_reg + 16'(idx_reg);
          mem_wdata_o <= rtc_reg[idx_reg[2:0]];
          idx_reg <= idx_reg + 5'h01;
          if (idx_reg == 5'(CLK_FIELDS - 1)) begin
            done_o <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_CLKCHK: begin
          done_o <= date_ok;
          err_o <= !date_ok;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // captured words for print and clock write
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && state_reg == ST_RDATA) begin
      if (op_reg == OP_PRINT) pbuf_reg[idx_reg[3:0]] <= mem_rdata_i[7:0];
      if (op_reg == OP_CLK_WR) stage_reg[idx_reg[2:0]] <= mem_rdata_i;
    end
  end

  // clock fields
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < CLK_FIELDS; i++) begin
        rtc_reg[i] <= (i == 0) ? YEAR_RST : (i < 3) ? ONE_RST : 16'h0000;
      end
      clock_data_o <= 16'h0000;
    end else if (ce_i) begin
      if (state_reg == ST_CLKCHK && date_ok) begin
        for (int i = 0; i < CLK_FIELDS; i++) rtc_reg[i] <= stage_reg[i];
      end
      clock_data_o <= (clock_sel_i < 3'(CLK_FIELDS)) ? rtc_reg[clock_sel_i] : 16'h0000;
    end
  end

  // enable edge history
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nv_prev_reg <= 1'b0;
      pr_prev_reg <= 1'b0;
    end else if (take) begin
      if (cmd_op_i == OP_NV) nv_prev_reg <= cmd_power_i;
      if (cmd_op_i == OP_PRINT) pr_prev_reg <= cmd_power_i;
    end
  end

  // filter constant and io refresh
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      filt_reg <= 7'h00;
      io_refresh_o <= 1'b0;
      io_dir_o <= 2'h0;
      io_first_o <= 16'h0000;
      io_count_o <= 16'h0000;
    end else if (ce_i) begin
      io_refresh_o <= 1'b0;
      if (scan_end_i) begin
        io_refresh_o <= 1'b1;
        io_dir_o <= 2'h3;
        io_first_o <= 16'h0000;
        io_count_o <= IO_ALL;
      end else if (take && cmd_power_i) begin
        if (cmd_op_i == OP_FILT) filt_reg <= filt_q(cmd_a_i, variant_stepped_i);
        if ((cmd_op_i == OP_REF_IN || cmd_op_i == OP_REF_OUT)
            && cmd_a_i[2:0] == 3'h0 && cmd_b_i[2:0] == 3'h0) begin
          io_refresh_o <= 1'b1;
          io_dir_o <= (cmd_op_i == OP_REF_IN) ? 2'h1 : 2'h2;
          io_first_o <= cmd_a_i;
          io_count_o <= cmd_b_i;
        end
      end
    end
  end

  for (genvar g = 0; g < FILT_POINTS; g++) begin : g_filt
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) filtered_input_points_o[g] <= 1'b0;
      else if (ce_i) filtered_input_points_o[g] <= !high_speed_i[g];
    end
  end

  // byte print pacing, one scan per strobe edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      pr_loaded_reg <= 1'b0;
      pr_phase_reg <= 1'b0;
      pr_len_reg <= 1'b0;
      pr_pos_reg <= 5'h00;
      print_strobe_point_o <= 1'b0;
      print_data_o <= 8'h00;
    end else if (ce_i) begin
      if (pr_cancel) begin
        busy_reg <= 1'b0;
        pr_loaded_reg <= 1'b0;
        print_strobe_point_o <= 1'b0;
      end else if (pr_begin) begin
        busy_reg <= 1'b1;
        pr_len_reg <= print_length_flag_i;
        pr_pos_reg <= 5'h00;
        pr_phase_reg <= 1'b0;
      end else if (pr_go) begin
        pr_loaded_reg <= 1'b1;
      end else if (pr_loaded_reg && scan_end_i) begin
        if (pr_phase_reg) begin
          print_strobe_point_o <= 1'b0;
          pr_pos_reg <= pr_pos_reg + 5'h01;
          pr_phase_reg <= 1'b0;
        end else if (pr_pos_reg == pr_lim || (pr_len_reg && pr_pos_reg != 5'h00
            && pbuf_reg[pr_pos_reg[3:0]] == 8'h00)) begin
          busy_reg <= 1'b0;
          pr_loaded_reg <= 1'b0;
        end else begin
          print_data_o <= pbuf_reg[pr_pos_reg[3:0]];
          print_strobe_point_o <= 1'b1;
          pr_phase_reg <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  AST_POT_RANGE: assert property (take && cmd_power_i && cmd_op_i == OP_POT
    && cmd_a_i > POT_MAX |=> err_o && state_reg == ST_IDLE) else $error("pot range");
  AST_POT_STORE: assert property (ce_i && state_reg == ST_POT
    |=> mem_wr_o && mem_wdata_o[15:8] == 8'h00) else $error("pot store");
  AST_FILT_CLAMP: assert property (filter_time_o <= FILT_MAX) else $error("clamp");
  AST_FILT_STEP: assert property ($changed(filter_time_o) && $past(variant_stepped_i)
    |-> filter_time_o[2:0] == 3'h0 && $countones(filter_time_o) <= 1) else $error("step");
  AST_FILT_HS: assert property (ce_i |=>
    (filtered_input_points_o & $past(high_speed_i)) == 16'h0000) else $error("hs");
  AST_REF_SCAN: assert property (ce_i && scan_end_i
    |=> io_refresh_o && io_count_o == IO_ALL) else $error("scan refresh");
  AST_NV_EDGE: assert property (take && cmd_op_i == OP_NV && cmd_power_i
    && nv_prev_reg |=> state_reg == ST_IDLE && done_o) else $error("nv edge");
  AST_NV_MAX: assert property (nv_tmr_reg <= 17'(NV_MAX)) else $error("nv max");
  AST_PR_BUSY: assert property ($rose(print_strobe_point_o) |-> busy_reg)
    else $error("strobe idle");
  AST_PR_CANCEL: assert property (pr_cancel |=> !busy_reg ##1 !print_strobe_point_o)
    else $error("cancel");
  AST_CLK_FAULT: assert property (take && cmd_op_i == OP_CLK_RD && cmd_power_i
    && rtc_fault_i |=> err_o ##1 !mem_wr_o) else $error("clock fault");
  AST_CLK_MONTH: assert property (rtc_reg[1] >= ONE_RST && rtc_reg[1] <= MONTH_MAX)
    else $error("month");
endmodule

// >>> pciu_mem_model.sv
// partner model: word memory, potentiometer bank and nonvolatile save sink
// assumes the unit reads with one-cycle latency and drives registered strobes
`timescale 1ns/1ps
module pciu_mem_model (
  input wire logic clk_sys_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  output logic [15:0] mem_rdata_o,
  input wire logic [7:0] pot_index_i,
  output logic [7:0] pot_value_o,
  input wire logic nv_valid_i,
  output logic nv_ready_o,
  input wire logic [15:0] nv_addr_i,
  input wire logic [15:0] nv_data_i
);
  logic [15:0] words [0:8191];
  logic [15:0] wr_q[$];
  logic [15:0] nv_q[$];
  logic stall = 1'b0;
  logic [3:0] cyc = 4'h0;
  initial mem_rdata_o = 16'h0000;
  // reading follows the index so a stale index shows up
  assign pot_value_o = pot_index_i ^ 8'hA5;
  assign nv_ready_o = !stall || cyc[1];
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 4'h1;
    if (mem_wr_i) begin
      words[mem_addr_i[12:0]] <= mem_wdata_i;
      wr_q.push_back(mem_addr_i);
    end
    // data is good for one cycle, then turns to its inverse
    mem_rdata_o <= mem_rd_i ? words[mem_addr_i[12:0]] : ~mem_rdata_o;
    if (nv_valid_i && nv_ready_o) begin
      nv_q.push_back(nv_addr_i);
      nv_q.push_back(nv_data_i);
    end
  end
endmodule

// >>> test_plc_io_clock_instruction_unit.sv
// self-checking bench for the io and clock instruction unit
// assumes pciu_pkg, pciu_unit, pciu_fifo and pciu_mem_model are compiled first
`timescale 1ns/1ps
module test_plc_io_clock_instruction_unit import pciu_pkg::*;;
  localparam int NVMIN = 20;
  localparam int NVMAX = 50;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic scan_end_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic cmd_power_i = 1'b0;
  logic variant_stepped_i = 1'b0;
  logic print_length_flag_i = 1'b0;
  logic rtc_fault_i = 1'b0;
  pciu_op_t cmd_op_i = OP_POT;
  logic [15:0] cmd_a_i = 16'h0000;
  logic [15:0] cmd_b_i = 16'h0000;
  logic [15:0] high_speed_i = 16'h00F0;
  logic [2:0] clock_sel_i = 3'h0;
  logic [15:0] mem_rdata_i, mem_addr_o, mem_wdata_o, io_first_o, io_count_o;
  logic [15:0] nv_addr_o, nv_data_o, filtered_input_points_o, clock_data_o;
  logic [7:0] pot_value_i, pot_index_o, print_data_o;
  logic [6:0] filter_time_o;
  logic [1:0] io_dir_o;
  logic nv_ready_i, cmd_ready_o, done_o, err_o, mem_rd_o, mem_wr_o, io_refresh_o;
  logic nv_valid_o, print_busy_flag_o, print_strobe_point_o, strobe_q, erred;
  logic [33:0] ref_info;
  logic [7:0] bytes[$];
  int fails = 0;
  int num_checks = 0;
  int refs = 0;
  int lat, i, n;

  pciu_unit #(.NV_MIN(NVMIN), .NV_MAX(NVMAX)) dut_u (
    .clk_sys_i, .rst_i, .ce_i, .scan_end_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i,
    .cmd_power_i, .cmd_a_i, .cmd_b_i, .done_o, .err_o, .mem_rd_o, .mem_wr_o,
    .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .pot_index_o, .pot_value_i,
    .variant_stepped_i, .high_speed_i, .filter_time_o, .filtered_input_points_o,
    .io_refresh_o, .io_dir_o, .io_first_o, .io_count_o, .nv_valid_o, .nv_ready_i,
    .nv_addr_o, .nv_data_o, .print_length_flag_i, .print_busy_flag_o,
    .print_strobe_point_o, .print_data_o, .rtc_fault_i, .clock_sel_i, .clock_data_o
  );
  pciu_mem_model mem_u (
    .clk_sys_i(clk_sys_i), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
    .pot_index_i(pot_index_o), .pot_value_o(pot_value_i), .nv_valid_i(nv_valid_o),
    .nv_ready_o(nv_ready_i), .nv_addr_i(nv_addr_o), .nv_data_i(nv_data_o)
  );

  always #25 clk_sys_i = ~clk_sys_i;

  // printer side: a byte is taken on each rising strobe
  always @(posedge clk_sys_i) begin
    #1;
    if (print_strobe_point_o && !strobe_q) bytes.push_back(print_data_o);
    strobe_q = print_strobe_point_o;
    if (io_refresh_o) begin
      refs++;
      ref_info = {io_dir_o, io_first_o, io_count_o};
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic issue(input pciu_op_t op, input logic pw, input logic [15:0] a, b);
    for (lat = 0; lat < 9 && !cmd_ready_o; lat++) @(negedge clk_sys_i);
    cmd_op_i = op;
    cmd_power_i = pw;
    cmd_a_i = a;
    cmd_b_i = b;
    cmd_valid_i = 1'b1;
    @(negedge clk_sys_i);
    cmd_valid_i = 1'b0;
    for (lat = 0; lat < 300 && !done_o && !err_o; lat++) @(negedge clk_sys_i);
    erred = err_o;
    chk(lat < 300, 1'b1);
    @(negedge clk_sys_i);
  endtask

  task automatic scan();
    scan_end_i = 1'b1;
    @(negedge clk_sys_i);
    scan_end_i = 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic t_reset();
    logic [15:0] rv [7] = '{16'h07D0, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    chk({cmd_ready_o, print_busy_flag_o, done_o}, 3'h4);
    for (i = 0; i < 7; i++) begin
      clock_sel_i = i[2:0];
      repeat (2) @(negedge clk_sys_i);
      chk(clock_data_o, rv[i]);
    end
  endtask

  task automatic t_pot();
    issue(OP_POT, 1'b1, 16'h0005, 16'h0100);
    chk({erred, mem_u.words[256]}, {1'b0, 16'h00A0});
    issue(OP_POT, 1'b1, 16'h00FF, 16'h0101);
    chk({erred, mem_u.words[257]}, {1'b0, 16'h005A});
    n = mem_u.wr_q.size();
    issue(OP_POT, 1'b1, 16'h0100, 16'h0102);
    chk({erred, mem_u.wr_q.size() == n}, 2'h3);
    issue(OP_POT, 1'b0, 16'h0003, 16'h0103);
    chk(mem_u.wr_q.size(), n);
  endtask

  task automatic t_filter();
    logic [15:0] rq [8] = '{16'h001E, 16'h0064, 16'h0040, 16'h001E, 16'h0007, 16'h000F,
      16'h003F, 16'h00C8};
    logic [6:0] ex [8] = '{7'h1E, 7'h40, 7'h40, 7'h10, 7'h00, 7'h08, 7'h20, 7'h40};
    for (i = 0; i < 8; i++) begin
      variant_stepped_i = i > 2;
      issue(OP_FILT, 1'b1, rq[i], 16'h0000);
      chk(filter_time_o, ex[i]);
    end
    issue(OP_FILT, 1'b0, 16'h0008, 16'h0000);
    chk(filter_time_o, 7'h40);
    chk(filtered_input_points_o, 16'hFF0F);
  endtask

  task automatic t_refresh();
    n = refs;
    issue(OP_REF_IN, 1'b1, 16'h0008, 16'h0010);
    chk({6'(refs - n), ref_info}, {6'h01, 2'h1, 16'h0008, 16'h0010});
    issue(OP_REF_OUT, 1'b1, 16'h0010, 16'h0008);
    chk({6'(refs - n), ref_info}, {6'h02, 2'h2, 16'h0010, 16'h0008});
    issue(OP_REF_IN, 1'b1, 16'h0004, 16'h0008);
    chk(refs - n, 2);
    scan();
    chk({6'(refs - n), ref_info}, {6'h03, 2'h3, 16'h0000, 16'h0100});
    ce_i = 1'b0;
    scan();
    ce_i = 1'b1;
    chk(refs - n, 3);
  endtask

  task automatic t_nv();
    for (i = 0; i < 3; i++) mem_u.words[6000 + i] = 16'h1230 + i[15:0];
    mem_u.nv_q.delete();
    mem_u.stall = 1'b1;
    issue(OP_NV, 1'b0, 16'h1770, 16'h0003);
    issue(OP_NV, 1'b1, 16'h1770, 16'h0003);
    chk({erred, lat >= NVMIN - 2 && lat <= NVMAX + 2}, 2'h1);
    chk(mem_u.nv_q.size(), 6);
    for (i = 0; i < 6; i++) chk(mem_u.nv_q[i], i[0] ? 16'h1230 + i / 2 : 16'h1770 + i / 2);
    issue(OP_NV, 1'b1, 16'h1770, 16'h0003);
    chk(mem_u.nv_q.size(), 6);
    issue(OP_NV, 1'b0, 16'h1B50, 16'h0008);
    issue(OP_NV, 1'b1, 16'h1B50, 16'h0008);
    chk(erred, 1'b1);
    issue(OP_NV, 1'b0, 16'h1770, 16'h0010);
    issue(OP_NV, 1'b1, 16'h1770, 16'h0010);
    chk({erred, mem_u.nv_q.size() == 6}, 2'h3);
    issue(OP_NV, 1'b0, 16'hFFFF, 16'h0001);
    issue(OP_NV, 1'b1, 16'hFFFF, 16'h0001);
    chk({erred, mem_u.nv_q.size() == 6}, 2'h3);
    mem_u.stall = 1'b0;
  endtask

  task automatic run_print(input logic [15:0] src);
    bytes.delete();
    issue(OP_PRINT, 1'b0, src, 16'h0000);
    issue(OP_PRINT, 1'b1, src, 16'h0000);
    chk(print_busy_flag_o, 1'b1);
    for (i = 0; i < 40 && print_busy_flag_o; i++) scan();
    chk(print_busy_flag_o, 1'b0);
  endtask

  task automatic t_print();
    for (i = 0; i < 16; i++) begin
      mem_u.words[512 + i] = {8'hFF, 8'h41 + i[7:0]};
      mem_u.words[528 + i] = (i == 3) ? 16'hFF00 : {8'hFF, 8'h61 + i[7:0]};
    end
    run_print(16'h0200);
    chk(bytes.size(), 8);
    for (i = 0; i < 8; i++) chk(bytes[i], 8'h41 + i[7:0]);
    issue(OP_PRINT, 1'b1, 16'h0200, 16'h0000);
    scan();
    chk({print_busy_flag_o, bytes.size() == 8}, 2'h1);
    print_length_flag_i = 1'b1;
    run_print(16'h0210);
    chk({8'(bytes.size()), bytes[0], bytes[2]}, {8'h03, 8'h61, 8'h63});
    run_print(16'h0200);
    chk(bytes.size(), 16);
    issue(OP_PRINT, 1'b0, 16'h0200, 16'h0000);
    issue(OP_PRINT, 1'b1, 16'h0200, 16'h0000);
    scan();
    issue(OP_PRINT, 1'b0, 16'h0200, 16'h0000);
    chk(print_busy_flag_o, 1'b0);
  endtask

  task automatic t_clock();
    logic [15:0] tv [7] = '{16'h07E8, 16'h0002, 16'h001D, 16'h000D, 16'h002D, 16'h001E, 16'h0004};
    for (i = 0; i < 7; i++) mem_u.words[768 + i] = tv[i];
    for (i = 0; i < 7; i++) mem_u.words[784 + i] = i ? tv[i] : 16'h07E7;
    issue(OP_CLK_WR, 1'b0, 16'h0300, 16'h0000);
    issue(OP_CLK_WR, 1'b1, 16'h0300, 16'h0000);
    chk(erred, 1'b0);
    issue(OP_CLK_WR, 1'b0, 16'h0310, 16'h0000);
    issue(OP_CLK_WR, 1'b1, 16'h0310, 16'h0000);
    chk(erred, 1'b1);
    issue(OP_CLK_RD, 1'b1, 16'h0000, 16'h0400);
    n = mem_u.wr_q.size();
    for (i = 0; i < 7; i++) chk({mem_u.wr_q[n - 7 + i], mem_u.words[1024 + i]},
      {16'h0400 + i[15:0], tv[i]});
    rtc_fault_i = 1'b1;
    issue(OP_CLK_RD, 1'b1, 16'h0000, 16'h0500);
    chk({erred, mem_u.wr_q.size() == n}, 2'h3);
    rtc_fault_i = 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys_i);
    fails++;
    complete_run();
  end

  initial begin
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b0;
    @(negedge clk_sys_i);
    t_reset();
    t_pot();
    t_filter();
    t_refresh();
    t_nv();
    t_print();
    t_clock();
    complete_run();
  end
endmodule
